// ===== src/wdt_pkg.sv
package wdt_pkg;
    // Service register location and values
    localparam logic [15:0] SERVICE_ADDR  = 16'hFF99;
    localparam logic [7:0]  SERVICE_KEY   = 8'hAC;
    localparam logic [7:0]  RST_VAL_ON    = 8'h9A;
    localparam logic [7:0]  RST_VAL_OFF   = 8'h1A;
    // Data accesses in this range are never illegal
    localparam logic [15:0] DATA_FREE_LO  = 16'hFB00;
    // Option byte field positions
    localparam int          OPT_WIN_LSB   = 5;
    localparam int          OPT_CEN_BIT   = 4;
    localparam int          OPT_OVF_LSB   = 1;
    localparam int          OPT_LOCK_BIT  = 0;
    // Overflow period is 2^(OVF_BASE_EXP + code) slow clocks
    localparam int          OVF_BASE_EXP  = 10;
    localparam int          CNT_W         = 17;
    localparam logic [7:0]  OPT_RESET     = 8'h00;

    typedef struct packed {
        logic [1:0] window_sel;
        logic       count_enable_option;
        logic [2:0] overflow_sel;
        logic       lowspeed_osc_lock_option;
    } option_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        bitop;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpu_bus_s;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic [15:0] addr;
    } mem_access_s;
endpackage : wdt_pkg

// ===== src/windowed_watchdog_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Writing ACH clears and restarts the counter
// R2 - Reset value 9AH if enabled, else 1AH
// R3 - Wrong value resets, deferred while clock stopped
// R4 - Bit-manipulation write resets, deferred likewise
// R5 - Reads return reset value, never written data
// R6 - Enable option starts counting and access checks
// R7 - Overflow select n gives 2^(10+n) clocks
// R8 - Overflow without service raises internal reset
// R9 - Window select gives 25/50/75/100 percent open
// R10 - Service while window closed raises reset
// R11 - First service ignores window, later ones checked
// R12 - Clear may shift overflow by two clocks
// R13 - Service at final count still clears counter
// R14 - Lock option 0 halts counting in HALT/STOP
// R15 - Leaving HALT/STOP resumes from held count
// R16 - Oscillator stop control halts and keeps count
// R17 - Counting continues during flash self-programming
// R18 - Shortest overflow with 25 percent forbidden
// R19 - Illegal fetch or data access raises reset
// R20 - Window closed first part after each restart
// R21 - Watchdog resets set the reset-cause flag
// R22 - Checks synchronised to slow clock, pulse out
// R23 - Bus qualifier marks bit-manipulation accesses
module windowed_watchdog_timer
    import wdt_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  option_byte,
    input  wire logic        lowspeed_clk,
    input  wire cpu_bus_s    cpu_bus,
    input  wire mem_access_s mem_access,
    input  wire logic [15:0] rom_limit,
    input  wire logic [15:0] ram_base,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        lowspeed_osc_stop_ctrl,
    input  wire logic        flag_clear,
    output logic [7:0]       bus_rdata,
    output logic             wdt_reset_req,
    output logic             watchdog_reset_flag,
    output logic             window_open
);

    // Last count before overflow for a select code
    function automatic logic [CNT_W-1:0] last_of(input logic [2:0] sel);
        logic [CNT_W:0] p;
        p = (CNT_W+1)'(1) << (OVF_BASE_EXP + int'(sel));
        return p[CNT_W-1:0] - 1'b1;
    endfunction : last_of

    // Length of the closed part of the window
    function automatic logic [CNT_W-1:0] closed_of(input logic [2:0] sel,
                                                    input logic [1:0] win);
        logic [CNT_W:0] p;
        logic [CNT_W:0] q;
        p = (CNT_W+1)'(1) << (OVF_BASE_EXP + int'(sel));
        q = (p >> 2) * (CNT_W+1)'(2'd3 - win);
        return q[CNT_W-1:0];
    endfunction : closed_of

    option_s          opt_q;
    logic             opt_loaded_q;
    logic             ls_meta_q;
    logic             ls_sync_q;
    logic             ls_prev_q;
    logic             tick;
    logic [CNT_W-1:0] cnt_q;
    logic             first_done_q;
    logic             svc_pend_q;
    logic             bad_pend_q;
    logic             wr_hit;
    logic             good_wr;
    logic             bad_wr;
    logic             running;
    logic             win_closed;
    logic             at_last;
    logic             illegal;
    logic             fire;
    logic             addr_legal;
    logic [7:0]       reset_value;

    // Option byte is caught once after reset release
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            opt_q        <= option_s'(OPT_RESET[6:0]);
            opt_loaded_q <= 1'b0;
        end else if (!opt_loaded_q) begin
            opt_q        <= option_s'(option_byte[6:0]);
            opt_loaded_q <= 1'b1;
        end
    end

    // Slow oscillator is a pin: two flops, then edge detect
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ls_meta_q <= 1'b0;
            ls_sync_q <= 1'b0;
            ls_prev_q <= 1'b0;
        end else begin
            ls_meta_q <= lowspeed_clk;
            ls_sync_q <= ls_meta_q;
            ls_prev_q <= ls_sync_q;
        end
    end

    assign tick = ls_sync_q & ~ls_prev_q;

    // Write decode; the bit-op qualifier marks single-bit writes
    assign wr_hit  = cpu_bus.wr && (cpu_bus.addr == SERVICE_ADDR);
    assign good_wr = wr_hit && !cpu_bus.bitop && (cpu_bus.wdata == SERVICE_KEY);
    assign bad_wr  = wr_hit && (cpu_bus.bitop || cpu_bus.wdata != SERVICE_KEY); // [R3] [R4] [R23]

    // Counting stops in low power only when the oscillator may stop
    assign running = opt_loaded_q && opt_q.count_enable_option          // [R6]
                     && (opt_q.lowspeed_osc_lock_option                 // [R14]
                         || !(halt_mode || stop_mode || lowspeed_osc_stop_ctrl)); // [R16]

    // Window closed for the leading part after each restart
    assign win_closed = opt_q.count_enable_option && first_done_q       // [R11]
                        && (cnt_q < closed_of(opt_q.overflow_sel,
                                              opt_q.window_sel));       // [R9] [R20]

    assign at_last = (cnt_q == last_of(opt_q.overflow_sel));            // [R7]

    // Legal memory areas come from the size register decode
    assign addr_legal = (mem_access.addr < rom_limit) || (mem_access.addr >= ram_base);

    assign illegal = opt_loaded_q && opt_q.count_enable_option && mem_access.valid
                     && !addr_legal
                     && (mem_access.fetch || mem_access.addr < DATA_FREE_LO); // [R19]

    // Write faults act on the next slow edge, so a stopped clock defers them
    assign fire = illegal
                  || (tick && bad_pend_q)                               // [R3] [R4]
                  || (tick && svc_pend_q && win_closed)                 // [R10]
                  || (tick && running && !svc_pend_q && at_last);       // [R8] [R13]

    // Pending service; a new write wins over the tick that consumes one
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            svc_pend_q <= 1'b0;
            bad_pend_q <= 1'b0;
        end else if (fire) begin
            svc_pend_q <= 1'b0;
            bad_pend_q <= 1'b0;
        end else begin
            svc_pend_q <= good_wr | (svc_pend_q & ~tick);               // [R22]
            bad_pend_q <= bad_wr | (bad_pend_q & ~tick);                // [R22]
        end
    end

    // Counter; clears take effect on a slow edge, hence up to two clocks of slip
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_q        <= '0;
            first_done_q <= 1'b0;
        end else if (fire) begin
            cnt_q        <= '0;
            first_done_q <= 1'b0;
        end else if (tick && svc_pend_q) begin
            cnt_q        <= '0;                                         // [R1] [R12] [R13]
            first_done_q <= 1'b1;                                       // [R11]
        end else if (tick && running) begin
            cnt_q        <= cnt_q + 1'b1;                               // [R15] [R17]
        end
    end

    // Reset request is one cycle wide; cause flag is sticky, set wins
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wdt_reset_req       <= 1'b0;
            watchdog_reset_flag <= 1'b0;
        end else begin
            wdt_reset_req       <= fire;                                // [R22]
            watchdog_reset_flag <= fire | (watchdog_reset_flag & ~flag_clear); // [R21]
        end
    end

    // Reads show the reset value only; written data is never stored
    assign reset_value = opt_q.count_enable_option ? RST_VAL_ON : RST_VAL_OFF; // [R2]

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            bus_rdata <= 8'h00;
        end else if (cpu_bus.rd && cpu_bus.addr == SERVICE_ADDR) begin
            bus_rdata <= reset_value;                                   // [R5]
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // Window status for software and debug
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            window_open <= 1'b0;
        end else begin
            window_open <= running && !win_closed;
        end
    end

    // Checks below share the core clock and rest while reset is held
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_pulse_single: assert property (wdt_reset_req |=> !wdt_reset_req) // [R22]
        else $error("reset request longer than one cycle");

    chk_read_value: assert property ( // [R5]
        cpu_bus.rd && cpu_bus.addr == SERVICE_ADDR && opt_loaded_q
        |=> bus_rdata == (opt_q.count_enable_option ? RST_VAL_ON : RST_VAL_OFF))
        else $error("service register read value wrong");

    chk_bad_write: assert property (tick && bad_pend_q |=> wdt_reset_req) // [R3]
        else $error("bad service write did not reset");

    chk_bitop_pend: assert property ( // [R4]
        wr_hit && cpu_bus.bitop && !fire |=> bad_pend_q)
        else $error("bit manipulation write not flagged");

    chk_service_clear: assert property ( // [R1]
        tick && svc_pend_q && !fire |=> cnt_q == '0 && first_done_q)
        else $error("service write did not clear counter");

    chk_overflow_reset: assert property ( // [R8]
        tick && running && !svc_pend_q && at_last |=> wdt_reset_req ##1 cnt_q == '0)
        else $error("overflow did not reset");

    chk_window_closed: assert property ( // [R10]
        tick && svc_pend_q && win_closed |=> wdt_reset_req)
        else $error("closed window service not caught");

    chk_hold_count: assert property ( // [R15]
        !running && !svc_pend_q && !fire |=> $stable(cnt_q))
        else $error("count changed while halted");

    chk_first_service: assert property ( // [R11]
        tick && svc_pend_q && !first_done_q && !bad_pend_q && !illegal
        |=> !wdt_reset_req)
        else $error("first service wrongly rejected");

    chk_illegal_access: assert property (illegal |=> wdt_reset_req)     // [R19]
        else $error("illegal access did not reset");

    chk_cause_flag: assert property (wdt_reset_req |-> watchdog_reset_flag) // [R21]
        else $error("cause flag not set");

    // The count can never run past the last value of the chosen period
    chk_count_bound: assert property (cnt_q <= last_of(opt_q.overflow_sel)) // [R7]
        else $error("counter passed the selected period");

    // Lock option set: low power modes must not stop the count
    chk_count_advance: assert property ( // [R14] [R17]
        tick && opt_loaded_q && opt_q.count_enable_option && opt_q.lowspeed_osc_lock_option
        && !svc_pend_q && !fire |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("count did not advance on a slow edge");

    // Lock option clear: any low power request freezes the count
    chk_low_power_hold: assert property ( // [R14] [R16]
        opt_loaded_q && !opt_q.lowspeed_osc_lock_option
        && (halt_mode || stop_mode || lowspeed_osc_stop_ctrl) && !svc_pend_q && !fire
        |=> $stable(cnt_q))
        else $error("count moved in a low power mode");

    // Enable option clear: the counter stays parked and the window shows shut
    chk_disabled_idle: assert property ( // [R6]
        opt_loaded_q && !opt_q.count_enable_option |=> cnt_q == '0 && !window_open)
        else $error("counter active with counting disabled");

    // A key write must leave a pending service for the next slow edge
    chk_key_pending: assert property (good_wr && !fire |=> svc_pend_q) // [R1] [R22]
        else $error("service write not held for the slow edge");

    // Each slow edge is seen for exactly one core cycle
    chk_tick_single: assert property (tick |=> !tick) // [R22]
        else $error("slow edge seen twice");

    // Any watchdog reset leaves a clean counter and no stale pending write
    chk_fault_clears: assert property ( // [R22]
        fire |=> cnt_q == '0 && !svc_pend_q && !bad_pend_q && !first_done_q)
        else $error("state left over after a watchdog reset");

    // Idle cycles and other addresses read as zero
    chk_rdata_idle: assert property ( // [R5]
        !(cpu_bus.rd && cpu_bus.addr == SERVICE_ADDR) |=> bus_rdata == 8'h00)
        else $error("read data present without a read");

    // The cause flag holds until software clears it
    chk_flag_sticky: assert property ( // [R21]
        watchdog_reset_flag && !flag_clear |=> watchdog_reset_flag)
        else $error("cause flag dropped without a clear");

    // Main scenarios; the last is a service landing on the final count
    cov_overflow: cover property (tick && running && at_last && !svc_pend_q);
    cov_good_service: cover property (tick && svc_pend_q && first_done_q && !win_closed);
    cov_window_fault: cover property (tick && svc_pend_q && win_closed);
    cov_halt_resume: cover property (!running && opt_q.count_enable_option ##1 running);
    cov_last_service: cover property (tick && svc_pend_q && at_last);

endmodule : windowed_watchdog_timer

// ===== verif/cpu_core_model.sv
`timescale 1ns/1ps
// Processor core side: single-cycle accesses to the service register
module cpu_core_model
    import wdt_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] bus_rdata,
    output cpu_bus_s        cpu_bus
);
    initial cpu_bus = '0;

    // One write; bitop marks a single-bit manipulation access
    task automatic svc_write(input logic [7:0] data, input logic bitop);
        @(posedge sys_clk);
        cpu_bus <= '{wr: 1'b1, rd: 1'b0, bitop: bitop, addr: SERVICE_ADDR, wdata: data};
        @(posedge sys_clk);
        // Released lines show junk so a stale value is never mistaken for data
        cpu_bus <= '{wr: 1'b0, rd: 1'b0, bitop: 1'b0, addr: ~SERVICE_ADDR, wdata: ~data};
    endtask : svc_write

    // Read data lands one cycle after the taken edge and stands one cycle
    task automatic svc_read(output logic [7:0] data);
        @(posedge sys_clk);
        cpu_bus <= '{wr: 1'b0, rd: 1'b1, bitop: 1'b0, addr: SERVICE_ADDR, wdata: 8'h00};
        @(posedge sys_clk);
        cpu_bus <= '{wr: 1'b0, rd: 1'b0, bitop: 1'b0, addr: ~SERVICE_ADDR, wdata: 8'hFF};
        #1 data = bus_rdata;
    endtask : svc_read
endmodule : cpu_core_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import wdt_pkg::*;
;
    localparam real SLOW_NS = 40.6;
    logic        sys_clk      = 1'b0;
    logic        resetn       = 1'b0;
    logic        lowspeed_clk = 1'b0;
    logic [7:0]  option_byte  = 8'h71;
    mem_access_s mem_access   = '0;
    logic        halt_mode    = 1'b0;
    logic        stop_mode    = 1'b0;
    logic        osc_stop     = 1'b0;
    logic        flag_clear   = 1'b0;
    cpu_bus_s    cpu_bus;
    logic [7:0]  bus_rdata;
    logic        wdt_reset_req;
    logic        watchdog_reset_flag;
    logic        window_open;
    logic [7:0]  rd_val;
    int          bad_count    = 0;
    int          n_compared   = 0;
    int          n;

    windowed_watchdog_timer u_dut (.sys_clk(sys_clk), .resetn(resetn), .option_byte(option_byte),
        .lowspeed_clk(lowspeed_clk), .cpu_bus(cpu_bus), .mem_access(mem_access), .rom_limit(16'h8000),
        .ram_base(16'hFC00), .halt_mode(halt_mode), .stop_mode(stop_mode), .lowspeed_osc_stop_ctrl(osc_stop),
        .flag_clear(flag_clear), .bus_rdata(bus_rdata), .wdt_reset_req(wdt_reset_req),
        .watchdog_reset_flag(watchdog_reset_flag), .window_open(window_open));
    cpu_core_model u_cpu (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .cpu_bus(cpu_bus));

    // Slow oscillator free-runs at an odd ratio so its phase drifts against the core clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        forever #20.3 lowspeed_clk = ~lowspeed_clk;
    end

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Slow ticks convert to core cycles; thirty core cycles of slack cover clear sync
    function automatic logic near(input int cyc, input int ticks);
        return (cyc > ticks * SLOW_NS / 5.0 - 30) && (cyc < ticks * SLOW_NS / 5.0 + 30);
    endfunction : near

    task automatic wait_req(input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && wdt_reset_req !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask : wait_req

    // Waits for the window output to reach a level, sampled just after each edge
    task automatic wait_win(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && window_open !== lvl) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask : wait_win

    // Shortest overflow is never paired with the 25 percent window
    task automatic do_reset(input logic [7:0] opt);
        @(posedge sys_clk);
        resetn      <= 1'b0;
        option_byte <= opt;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
    endtask : do_reset

    task automatic t_read;
        do_reset(8'h62);
        u_cpu.svc_read(rd_val);
        check(rd_val, RST_VAL_OFF);
        do_reset(8'h71);
        u_cpu.svc_write(SERVICE_KEY, 1'b0);
        u_cpu.svc_read(rd_val);
        check(rd_val, RST_VAL_ON);
        $display("test read done");
    endtask : t_read

    task automatic t_bad;
        do_reset(8'h71);
        u_cpu.svc_write(8'h5A, 1'b0);
        wait_req(60, n);
        check(n < 60, 1);
        @(posedge sys_clk);
        flag_clear <= 1'b1;
        #1 check(watchdog_reset_flag, 1);
        @(posedge sys_clk);
        flag_clear <= 1'b0;
        #1 check(watchdog_reset_flag, 0);
        do_reset(8'h71);
        u_cpu.svc_write(SERVICE_KEY, 1'b1);
        wait_req(60, n);
        check(n < 60, 1);
        $display("test bad writes done");
    endtask : t_bad

    task automatic t_window;
        do_reset(8'h13);
        u_cpu.svc_write(SERVICE_KEY, 1'b0);
        wait_req(400, n);
        check(n, 400);
        u_cpu.svc_write(SERVICE_KEY, 1'b0);
        wait_req(60, n);
        check(n < 60, 1);
        do_reset(8'h13);
        u_cpu.svc_write(SERVICE_KEY, 1'b0);
        wait_win(1'b0, 40, n);
        check(n < 40, 1);
        wait_win(1'b1, 20000, n);
        check(near(n, 1536), 1);
        u_cpu.svc_write(SERVICE_KEY, 1'b0);
        wait_req(400, n);
        check(n, 400);
        $display("test window done");
    endtask : t_window

    task automatic t_overflow;
        do_reset(8'h71);
        repeat (40) @(posedge sys_clk);
        halt_mode <= 1'b1;
        #1 check(window_open, 1);
        wait_req(20000, n);
        check(near(n + 40, 1024), 1);
        @(posedge sys_clk);
        halt_mode <= 1'b0;
        $display("test overflow done");
    endtask : t_overflow

    // Lock option off: halt, stop and oscillator stop each freeze the count in turn
    task automatic t_halt;
        do_reset(8'h70);
        repeat (4000) @(posedge sys_clk);
        halt_mode <= 1'b1;
        repeat (3000) @(posedge sys_clk);
        halt_mode <= 1'b0;
        stop_mode <= 1'b1;
        repeat (3000) @(posedge sys_clk);
        stop_mode <= 1'b0;
        osc_stop  <= 1'b1;
        repeat (2000) @(posedge sys_clk);
        osc_stop  <= 1'b0;
        wait_req(20000, n);
        check(near(n + 4000, 1024), 1);
        $display("test halt done");
    endtask : t_halt

    task automatic t_illegal;
        do_reset(8'h62);
        @(posedge sys_clk);
        mem_access <= '{valid: 1'b1, fetch: 1'b1, addr: 16'h9000};
        @(posedge sys_clk);
        mem_access <= '0;
        #1 check(wdt_reset_req, 0);
        do_reset(8'h71);
        @(posedge sys_clk);
        mem_access <= '{valid: 1'b1, fetch: 1'b0, addr: 16'hFB10};
        @(posedge sys_clk);
        mem_access <= '{valid: 1'b1, fetch: 1'b1, addr: 16'h9000};
        #1 check(wdt_reset_req, 0);
        @(posedge sys_clk);
        mem_access <= '0;
        #1 check(wdt_reset_req, 1);
        @(posedge sys_clk);
        mem_access <= '{valid: 1'b1, fetch: 1'b0, addr: 16'h9000};
        @(posedge sys_clk);
        mem_access <= '0;
        #1 check(wdt_reset_req, 1);
        $display("test illegal access done");
    endtask : t_illegal

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        t_read();
        t_bad();
        t_window();
        t_overflow();
        t_halt();
        t_illegal();
        end_sim();
    end

    // Tests need about 40k cycles; allow roughly twice that
    initial begin
        repeat (80000) @(posedge sys_clk);
        bad_count++;
        end_sim();
    end
endmodule : tb_top
